// [verilog/seb_params.svh]
// Behaviour
// - Start condition opens every command
// - Watch lines; no command without start
// - Stop condition ends current command
// - Units are eight bits plus acknowledge
// - Receiver pulls data low on ninth clock
// - Transmitter releases data after eight bits
// - Acknowledge matching target address
// - Acknowledge word-address and write bytes
// - Controller ack low: send next byte
// - No ack: release, await stop, end
// - Upper four bits match fixed type code
// - Next two bits match strap pins
// - Address bit zero: 0 write, 1 read
// - Page-select bit forms memory address
// - Unused select pin ignored in matching
// - Stop after full write byte starts programming
// - No commands up to five ms after programming
// - Programming: ignore commands, no acknowledge
// - Write-protect high blocks all writes
`ifndef SEB_PARAMS_SVH
`define SEB_PARAMS_SVH
// arbitrary type code, not tied to any real part
`define SEB_TYPE_CODE 4'h6
`define SEB_TYPE_MSB 7
`define SEB_SEL_HI_BIT 3
`define SEB_SEL_LO_BIT 2
`define SEB_PAGE_BIT 1
`define SEB_RW_BIT 0
`define SEB_PROG_TIME_US 5000
`define SEB_CLK_MHZ 100
`define SEB_PROG_CYCLES (`SEB_PROG_TIME_US * `SEB_CLK_MHZ)
`define SEB_FIFO_DEPTH 8
`define SEB_BYTE_RESET 8'h00
`endif

// [verilog/seb_pkg.sv]
package seb_pkg;
	typedef logic [7:0] seb_byte_t;
	// one received byte with its role in the command
	typedef struct packed {
		logic is_addr;
		logic page;
		seb_byte_t data;
	} seb_wr_s;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEV = 3'b001,
		ST_WORD = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100,
		ST_WAITP = 3'b101
	} seb_state_e;
endpackage : seb_pkg

// [verilog/seb_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module seb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wr_r;
	logic [AW:0] rd_r;
	logic full;
	logic empty;
	assign empty = (wr_r == rd_r);
	assign full = (wr_r[AW-1:0] == rd_r[AW-1:0]) && (wr_r[AW] != rd_r[AW]);
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem_r[rd_r[AW-1:0]];
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			wr_r <= '0;
		end else if (in_valid_i && !full) begin
			wr_r <= wr_r + 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (in_valid_i && !full) begin
			mem_r[wr_r[AW-1:0]] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_r <= '0;
		end else if (out_ready_i && !empty) begin
			rd_r <= rd_r + 1'b1;
		end
	end
endmodule : seb_fifo
`default_nettype wire

// [verilog/seb_target.sv]
`timescale 1ns/100ps
`default_nettype none
`include "seb_params.svh"
module seb_target #(
	parameter int PROG_CYCLES = `SEB_PROG_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic sel_low_i,
	input wire logic sel_high_i,
	input wire logic unused_select_pin_i,
	input wire logic write_protect_i,
	output seb_pkg::seb_wr_s wr_data_o,
	output logic wr_valid_o,
	input wire logic wr_ready_i,
	output logic prog_start_o,
	output logic programming_o,
	output logic rd_req_o,
	input wire logic [7:0] rd_data_i,
	output logic busy_o
);
	import seb_pkg::*;
	// ==========================================================
	// pin synchronisers
	logic [1:0] scl_s_r;
	logic [1:0] sda_s_r;
	logic [1:0] sl_s_r;
	logic [1:0] sh_s_r;
	logic [1:0] wp_s_r;
	logic scl_d_r;
	logic sda_d_r;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			scl_s_r <= 2'h3;
			sda_s_r <= 2'h3;
			sl_s_r <= 2'h0;
			sh_s_r <= 2'h0;
			wp_s_r <= 2'h3;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_s_r <= {scl_s_r[0], scl_i};
			sda_s_r <= {sda_s_r[0], sda_i};
			sl_s_r <= {sl_s_r[0], sel_low_i};
			sh_s_r <= {sh_s_r[0], sel_high_i};
			wp_s_r <= {wp_s_r[0], write_protect_i};
			scl_d_r <= scl_s_r[1];
			sda_d_r <= sda_s_r[1];
		end
	end
	logic scl;
	logic sda;
	assign scl = scl_s_r[1];
	assign sda = sda_s_r[1];
	// ==========================================================
	// bus conditions
	logic start_c;
	logic stop_c;
	logic scl_rise;
	logic scl_fall;
	assign start_c = scl && scl_d_r && sda_d_r && !sda;
	assign stop_c = scl && scl_d_r && !sda_d_r && sda;
	assign scl_rise = scl && !scl_d_r;
	assign scl_fall = !scl && scl_d_r;
	// ==========================================================
	// transfer state
	seb_state_e state_r;
	logic [3:0] bit_r;
	logic [7:0] shift_r;
	logic ack_phase_r;
	logic rw_r;
	logic page_r;
	logic wbyte_done_r;
	logic [7:0] tx_r;
	logic sda_low_r;
	logic prog_r;
	logic [$clog2(`SEB_PROG_CYCLES+1)-1:0] prog_cnt_r;
	logic fifo_ready;
	logic byte_done;
	logic addr_match;
	assign byte_done = scl_rise && !ack_phase_r && (bit_r == 4'h7);
	// unused select pin never enters the compare
	assign addr_match = ({shift_r[6:0], sda} >> 4) == {4'h0, `SEB_TYPE_CODE}
		&& shift_r[`SEB_SEL_HI_BIT-1] == sh_s_r[1]
		&& shift_r[`SEB_SEL_LO_BIT-1] == sl_s_r[1];
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= ST_IDLE;
			bit_r <= 4'h0;
			shift_r <= `SEB_BYTE_RESET;
			ack_phase_r <= 1'b0;
			rw_r <= 1'b0;
			page_r <= 1'b0;
			wbyte_done_r <= 1'b0;
		end else if (stop_c) begin
			state_r <= ST_IDLE;
			ack_phase_r <= 1'b0;
			wbyte_done_r <= 1'b0;
		end else if (start_c) begin
			// no command during programming
			state_r <= prog_r ? ST_IDLE : ST_DEV;
			bit_r <= 4'h0;
			ack_phase_r <= 1'b0;
			wbyte_done_r <= 1'b0;
		end else if (state_r != ST_IDLE && state_r != ST_WAITP) begin
			if (scl_rise && !ack_phase_r) begin
				shift_r <= {shift_r[6:0], sda};
				bit_r <= bit_r + 4'h1;
			end
			if (byte_done) begin
				ack_phase_r <= 1'b1;
				bit_r <= 4'h0;
				unique case (state_r)
					ST_DEV: begin
						if (addr_match) begin
							rw_r <= sda;
							page_r <= shift_r[`SEB_PAGE_BIT-1];
						end else begin
							state_r <= ST_WAITP;
						end
					end
					ST_WDATA: wbyte_done_r <= 1'b1;
					default: ;
				endcase
			end else if (scl_rise && ack_phase_r) begin
				ack_phase_r <= 1'b0;
				unique case (state_r)
					ST_DEV: state_r <= rw_r ? ST_RDATA : ST_WORD;
					ST_WORD: state_r <= ST_WDATA;
					ST_RDATA: if (sda) state_r <= ST_WAITP;
					default: ;
				endcase
			end
		end
	end
	// ==========================================================
	// open-drain driver, changes on falling clock edge
	logic ack_now;
	assign ack_now = ack_phase_r && state_r != ST_RDATA
		&& (state_r == ST_DEV || state_r == ST_WORD || state_r == ST_WDATA);
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sda_low_r <= 1'b0;
			tx_r <= `SEB_BYTE_RESET;
			rd_req_o <= 1'b0;
		end else begin
			rd_req_o <= 1'b0;
			if (start_c || stop_c) begin
				sda_low_r <= 1'b0;
			end else if (scl_fall) begin
				if (ack_now) begin
					sda_low_r <= 1'b1;
				end else if (state_r == ST_RDATA && !ack_phase_r) begin
					if (bit_r == 4'h0) begin
						tx_r <= {rd_data_i[6:0], 1'b0};
						sda_low_r <= !rd_data_i[7];
						rd_req_o <= 1'b1;
					end else begin
						tx_r <= {tx_r[6:0], 1'b0};
						sda_low_r <= !tx_r[7];
					end
				end else begin
					sda_low_r <= 1'b0;
				end
			end
		end
	end
	assign sda_o = 1'b0;
	assign busy_o = programming_o;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sda_oe_o <= 1'b0;
		end else begin
			sda_oe_o <= sda_low_r && !start_c && !stop_c;
		end
	end
	// ==========================================================
	// write path through the fifo; a full fifo drops the byte, ack still given
	seb_wr_s wr_in;
	logic wr_push;
	assign wr_in = '{is_addr: (state_r == ST_WORD), page: page_r,
		data: {shift_r[6:0], sda}};
	assign wr_push = byte_done && (state_r == ST_WORD || state_r == ST_WDATA)
		&& !wp_s_r[1];
	seb_fifo #(.WIDTH($bits(seb_wr_s)), .DEPTH(`SEB_FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.in_valid_i(wr_push),
		.in_ready_o(fifo_ready),
		.in_data_i(wr_in),
		.out_valid_o(wr_valid_o),
		.out_ready_i(wr_ready_i),
		.out_data_o(wr_data_o)
	);
	// ==========================================================
	// programming timer
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			prog_r <= 1'b0;
			prog_cnt_r <= '0;
			prog_start_o <= 1'b0;
		end else begin
			prog_start_o <= 1'b0;
			if (stop_c && wbyte_done_r && !wp_s_r[1] && !prog_r) begin
				prog_r <= 1'b1;
				prog_start_o <= 1'b1;
				prog_cnt_r <= $bits(prog_cnt_r)'(PROG_CYCLES - 1);
			end else if (prog_r) begin
				if (prog_cnt_r == '0) begin
					prog_r <= 1'b0;
				end else begin
					prog_cnt_r <= prog_cnt_r - 1'b1;
				end
			end
		end
	end
	assign programming_o = prog_r;
	// ==========================================================
	// checks
	sequence s_prog_go;
		stop_c && wbyte_done_r && !wp_s_r[1] && !prog_r;
	endsequence
	a_prog_start: assert property (@(posedge clk_i) disable iff (reset_i)
		s_prog_go |=> prog_r && prog_start_o)
		else $error("programming did not start");
	a_prog_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
		prog_r && start_c |=> state_r == ST_IDLE)
		else $error("command taken while programming");
	a_wp_block: assert property (@(posedge clk_i) disable iff (reset_i)
		wp_s_r[1] |=> $stable(u_fifo.wr_r))
		else $error("write accepted while protected");
	a_stop_idle: assert property (@(posedge clk_i) disable iff (reset_i)
		stop_c |=> state_r == ST_IDLE)
		else $error("stop did not end command");
	a_oe_stop: assert property (@(posedge clk_i) disable iff (reset_i)
		stop_c |=> !sda_oe_o)
		else $error("line held at stop");
	a_mismatch_rel: assert property (@(posedge clk_i) disable iff (reset_i)
		state_r == ST_WAITP |-> ##2 !sda_oe_o)
		else $error("line driven after mismatch");
	a_start_dev: assert property (@(posedge clk_i) disable iff (reset_i)
		start_c && !stop_c && !prog_r |=> state_r == ST_DEV)
		else $error("start not taken");
	a_idle_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
		state_r == ST_IDLE ##1 state_r == ST_IDLE |-> ##1 !sda_oe_o)
		else $error("driven without a command");
endmodule : seb_target
`default_nettype wire

// [dv/seb_ctl_model.sv]
`timescale 1ns/100ps
`default_nettype none
module seb_ctl_model #(
	parameter int HALF = 16
) (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// ==========================================
	// bus controller: clock stands high between frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	task automatic start();
		tick(4);
		sda_o <= 1'b1;
		tick(HALF);
		scl_o <= 1'b1;
		tick(HALF);
		sda_o <= 1'b0;
		tick(HALF);
		scl_o <= 1'b0;
	endtask : start
	task automatic stop();
		tick(4);
		sda_o <= 1'b0;
		tick(HALF);
		scl_o <= 1'b1;
		tick(HALF);
		sda_o <= 1'b1;
		tick(HALF);
	endtask : stop
	// data moves well after the clock fall, never near it
	task automatic bit_io(input logic b, output logic s);
		tick(4);
		sda_o <= b;
		tick(HALF);
		scl_o <= 1'b1;
		tick(HALF);
		s = sda_i;
		scl_o <= 1'b0;
	endtask : bit_io
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask : wbyte
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(~ack, s);
	endtask : rbyte
endmodule : seb_ctl_model
`default_nettype wire

// [dv/serial_eeprom_bus_slave_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "seb_params.svh"
module serial_eeprom_bus_slave_bench;
	import seb_pkg::*;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic sel_lo = 1'b1;
	logic sel_hi = 1'b0;
	logic unused_pin = 1'b0;
	logic wp = 1'b0;
	logic wr_ready = 1'b1;
	logic [7:0] rd_data;
	logic scl, ctl_sda, sda_o, sda_oe, wr_valid, prog_start, prog;
	logic rd_req, busy, ack;
	seb_wr_s wr_data;
	seb_wr_s got_q[$], exp_q[$];
	logic [31:0] rs = 32'h24;
	int failures = 0, cmp_count = 0, n_prog = 0, rd_n = 0;
	// open drain with pull-up
	wire logic sda = ctl_sda & (~sda_oe | sda_o);
	assign rd_data = rd_pat(rd_n);
	initial forever #5 clk_i = ~clk_i;
	seb_target #(.PROG_CYCLES(2000)) dut_u (.clk_i(clk_i), .reset_i(reset_i),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.sel_low_i(sel_lo), .sel_high_i(sel_hi),
		.unused_select_pin_i(unused_pin), .write_protect_i(wp),
		.wr_data_o(wr_data), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
		.prog_start_o(prog_start), .programming_o(prog),
		.rd_req_o(rd_req), .rd_data_i(rd_data), .busy_o(busy));
	seb_ctl_model ctl_u (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
		.sda_o(ctl_sda));
	always @(posedge clk_i) begin
		if (wr_valid === 1'b1 && wr_ready === 1'b1) got_q.push_back(wr_data);
		if (prog_start === 1'b1) n_prog++;
		if (rd_req === 1'b1) rd_n <= rd_n + 1;
	end
	// ==========================================
	// helpers
	function automatic logic [7:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs[7:0];
	endfunction : rnd
	function automatic logic [7:0] rd_pat(input int n);
		return 8'(n * 37 + 8'h5C);
	endfunction : rd_pat
	function automatic logic [7:0] dev(input logic pg, input logic rw);
		return {`SEB_TYPE_CODE, sel_hi, sel_lo, pg, rw};
	endfunction : dev
	task automatic chk(input string nm, input logic [9:0] e, logic [9:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results
	task automatic wait_idle();
		for (int i = 0; prog !== 1'b0; i++) begin
			if (i > 3000) begin
				failures++;
				results();
			end
			@(posedge clk_i);
		end
	endtask : wait_idle
	task automatic drain();
		for (int i = 0; i < 50 && got_q.size() < exp_q.size(); i++)
			@(posedge clk_i);
		chk("fifo_n", 10'(exp_q.size()), 10'(got_q.size()));
		foreach (exp_q[i])
			chk("fifo", exp_q[i], i < got_q.size() ? got_q[i] : 'x);
		$display("test done, %0d bytes", exp_q.size());
		exp_q.delete();
		got_q.delete();
	endtask : drain
	task automatic wr_cmd(input logic pg, input int nb, input int lim);
		logic [7:0] d;
		ctl_u.start();
		ctl_u.wbyte(dev(pg, 1'b0), ack);
		chk("addr_ack", 10'h1, {9'h0, ack});
		for (int i = 0; i <= nb; i++) begin
			d = rnd();
			ctl_u.wbyte(d, ack);
			chk("data_ack", 10'h1, {9'h0, ack});
			if (exp_q.size() < lim) exp_q.push_back({i == 0, pg, d});
		end
		ctl_u.stop();
	endtask : wr_cmd
	task automatic rd_cmd(input int nb);
		logic [7:0] d;
		int base;
		base = rd_n;
		d = rnd();
		ctl_u.start();
		ctl_u.wbyte(dev(1'b1, 1'b0), ack);
		ctl_u.wbyte(d, ack);
		exp_q.push_back({2'b11, d});
		ctl_u.start();
		ctl_u.wbyte(dev(1'b1, 1'b1), ack);
		chk("rd_ack", 10'h1, {9'h0, ack});
		for (int k = 0; k < nb; k++) begin
			ctl_u.rbyte(k < nb - 1, d);
			chk("rdata", {2'b0, rd_pat(base + k)}, {2'b0, d});
		end
		chk("rd_rel", 10'h0, {9'h0, sda_oe});
		chk("sda_level", 10'h0, {9'h0, sda_o});
		ctl_u.stop();
	endtask : rd_cmd
	// ==========================================
	// scenarios
	initial begin
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		for (int t = 0; t < 4; t++) begin
			unused_pin <= rnd() > 8'h7F;
			wr_cmd(t[0], t + 1, 99);
			chk("prog", 10'(t + 1), 10'(n_prog));
			chk("busy", 10'h1, {9'h0, busy});
			ctl_u.start();
			ctl_u.wbyte(dev(1'b0, 1'b0), ack);
			ctl_u.stop();
			chk("busy_ack", 10'h0, {9'h0, ack});
			wait_idle();
			drain();
		end
		for (int m = 0; m < 3; m++) begin
			ctl_u.start();
			ctl_u.wbyte(dev(1'b0, 1'b0) ^ (8'h04 << m), ack);
			chk("miss_ack", 10'h0, {9'h0, ack});
			ctl_u.wbyte(rnd(), ack);
			chk("miss_rel", 10'h0, {9'h0, ack});
			ctl_u.stop();
		end
		$display("test done, mismatched addresses");
		rd_cmd(3);
		// other strap levels, address bytes follow them
		sel_lo <= 1'b0;
		sel_hi <= 1'b1;
		rd_cmd(1);
		drain();
		wp <= 1'b1;
		wr_cmd(1'b1, 2, 0);
		chk("wp_prog", 10'd4, 10'(n_prog));
		wp <= 1'b0;
		got_q.delete();
		$display("test done, write protect");
		wr_ready <= 1'b0;
		wr_cmd(1'b1, 10, `SEB_FIFO_DEPTH);
		wr_ready <= 1'b1;
		drain();
		wait_idle();
		results();
	end
endmodule : serial_eeprom_bus_slave_bench
`default_nettype wire
